// ===== hdl/rtw_pkg.sv
// Shared constants, types and tables of the raw track write command decoder
package rtw_pkg;

   // ****************************************
   // Command descriptor layout
   // ****************************************
   localparam int CDB_LEN = 10;
   localparam logic [3:0] CDB_LAST = 4'h9;
   localparam int B_OP = 0;
   localparam int B_FLAGS = 1;
   localparam int B_CYL_HI = 2;
   localparam int B_CYL_LO = 3;
   localparam int B_HEAD = 4;
   localparam int B_SECT = 5;
   localparam int B_LEN_HI = 7;
   localparam int B_LEN_LO = 8;
   localparam int PHYS_BIT = 0;
   localparam logic [7:0] OP_REFORMAT = 8'hED;
   localparam logic [7:0] OP_WRFULL = 8'hFC;
   localparam logic [15:0] FULL_BLK_LEN = 16'h020C;

   // ****************************************
   // Sense keys
   // ****************************************
   localparam logic [3:0] SK_NONE = 4'h0;
   localparam logic [3:0] SK_MEDIUM = 4'h3;
   localparam logic [3:0] SK_ILLEGAL = 4'h5;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_ERR = 4'h2;
   localparam logic [3:0] REG_ADDR = 4'h3;
   localparam logic [3:0] REG_LEN = 4'h4;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_CLR_BIT = 1;
   localparam logic CTRL_EN_RESET = 1'b1;

   // ****************************************
   // Drive error codes, index = fault input bit
   // ****************************************
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam int NUM_FAULTS = 30;
   localparam logic [7:0] ERR_TBL [0:NUM_FAULTS-1] = '{
      8'h03, 8'h04, 8'h05, 8'h06,         // RL11
      8'h07, 8'h0A, 8'h0B,                // RL12
      8'h0C, 8'h0E,                       // RL13
      8'h0F, 8'h10, 8'h11,                // RL14
      8'h12, 8'h13, 8'h16,                // RL15
      8'h14, 8'h15,                       // RL16
      8'h17, 8'h18, 8'h19,
      8'h1A, 8'h1B, 8'h1C,                // RL17
      8'h1E, 8'h1F, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25 // RL18
   };

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      ST_CDB = 3'b000,
      ST_DECODE = 3'b001,
      ST_FMT = 3'b010,
      ST_LOCATE = 3'b011,
      ST_XFER = 3'b100,
      ST_WDONE = 3'b101
   } rtw_state_t;

   typedef struct packed {
      logic [15:0] cyl;
      logic [7:0] head;
      logic [7:0] sect;
      logic [15:0] len;
   } rtw_fmt_req_t;

   typedef struct packed {
      logic phys;
      logic first_phys_only;
      logic [31:0] lba;
      logic [15:0] cyl;
      logic [7:0] head;
      logic [7:0] sect;
   } rtw_loc_req_t;

   typedef struct packed {
      logic done;
      logic good;
      logic [3:0] sense;
   } rtw_status_t;

   typedef struct packed {
      rtw_state_t st;
      logic [CDB_LEN-1:0][7:0] cdb;
      logic [3:0] idx;
      logic [15:0] cnt;
      logic [7:0] wbyte;
      logic wfull;
      logic en;
      logic [7:0] err;
      logic [31:0] rdata;
      logic done;
      logic good;
      logic [3:0] sense;
      logic fmt_go;
      logic loc_go;
   } rtw_regs_t;

endpackage

// ===== hdl/rtw_err_encoder.sv
// Priority encoder from fault inputs to the drive error code
`timescale 1ns/10ps
`default_nettype none
module rtw_err_encoder
   import rtw_pkg::*;
(
   // Fault conditions, one bit each
   input wire logic [NUM_FAULTS-1:0] faults,
   // Encoded code, zero when no fault
   output logic [7:0] code
);

   // Lowest fault index wins; only listed codes can come out
   function automatic logic [7:0] encode(input logic [NUM_FAULTS-1:0] f);
      logic [7:0] c;
      c = ERR_NONE;
      for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
         if (f[i]) begin
            c = ERR_TBL[i]; // RL19
         end
      end
      return c;
   endfunction

   always_comb begin
      code = encode(faults); // RL10
   end

endmodule
`default_nettype wire

// ===== hdl/rtw_cmd_decoder.sv
// Raw track write command decoder: descriptor parse, length check, data phase, error code
// Contract
// RL1: Reformat command reformats the whole addressed track per length setting.
// RL2: Reformat takes cylinder from bytes 2-3, head byte 4, ignores sector.
// RL3: Raw write stores the block exactly as the initiator supplies it.
// RL4: Select bit clear: logical address, position verified, first physical block only.
// RL5: Select bit set: cylinder bytes 2-3, head byte 4, sector byte 5.
// RL6: Only a transfer length of 524 is accepted, else illegal request.
// RL7: Raw write succeeds only if the preceding sector header reads.
// RL8: Initiator sends modified block data read earlier, header stripped.
// RL9: Initiator matches logical to physical block size to reach all blocks.
// RL10: Error code zero means no error.
// RL11: Distinct codes for servo processor power-on faults.
// RL12: Distinct codes for command parity, illegal command, bad seek address.
// RL13: Distinct codes for bad nonvolatile address and write timeout.
// RL14: Distinct codes for spin-up failure and readiness timeouts.
// RL15: Distinct codes for seek unspun, no tracking, recalibrate retries exhausted.
// RL16: Distinct codes for offset bounds failure and persistent fault.
// RL17: Distinct codes for head alignment needed, critical, limit exceeded.
// RL18: Separate timeout code for each servo operation.
// RL19: Error code is eight bits and never a reserved value.
// RL20: Initiator sends ten-byte descriptor: opcode, flags, address, control.
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module rtw_cmd_decoder
   import rtw_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Descriptor bytes from the bus front end
   input wire logic cdb_valid,
   input wire logic [7:0] cdb_byte,
   output logic cdb_ready,
   // Write data phase bytes from the initiator
   input wire logic din_valid,
   input wire logic [7:0] din_byte,
   output logic din_ready,
   // Track reformat engine
   output logic fmt_start,
   output rtw_fmt_req_t fmt_req,
   input wire logic fmt_done,
   input wire logic fmt_ok,
   // Block locate and prior header check
   output logic loc_start,
   output rtw_loc_req_t loc_req,
   input wire logic loc_done,
   input wire logic loc_hdr_ok,
   input wire logic loc_pos_ok,
   // Raw block writer
   output logic wr_valid,
   output logic [7:0] wr_byte,
   input wire logic wr_ready,
   input wire logic wr_done,
   input wire logic wr_ok,
   // Command completion
   output rtw_status_t status,
   // Servo and drive faults, error code
   input wire logic [NUM_FAULTS-1:0] faults,
   output logic [7:0] drive_error_code
);

   rtw_regs_t s;
   rtw_regs_t n;
   logic [7:0] enc_code;
   logic err_clr;

   // ****************************************
   // Descriptor field helpers
   // ****************************************
   function automatic logic [15:0] cdb_cyl(input logic [CDB_LEN-1:0][7:0] c);
      return {c[B_CYL_HI], c[B_CYL_LO]};
   endfunction

   function automatic logic [15:0] cdb_len(input logic [CDB_LEN-1:0][7:0] c);
      return {c[B_LEN_HI], c[B_LEN_LO]};
   endfunction

   rtw_err_encoder u_enc (
      .faults(faults),
      .code(enc_code)
   );

   // ****************************************
   // Outputs
   // ****************************************
   always_comb begin
      reg_rdata = s.rdata;
      cdb_ready = (s.st == ST_CDB) && s.en;
      din_ready = (s.st == ST_XFER) && (s.cnt != FULL_BLK_LEN) && (!s.wfull || wr_ready);
      wr_valid = s.wfull;
      wr_byte = s.wbyte; // RL3
      fmt_start = s.fmt_go;
      fmt_req.cyl = cdb_cyl(s.cdb); // RL2
      fmt_req.head = s.cdb[B_HEAD]; // RL2
      fmt_req.sect = 8'h00; // RL2
      fmt_req.len = cdb_len(s.cdb); // RL1
      loc_start = s.loc_go;
      loc_req.phys = s.cdb[B_FLAGS][PHYS_BIT];
      loc_req.first_phys_only = !s.cdb[B_FLAGS][PHYS_BIT]; // RL4 RL9
      loc_req.lba = {s.cdb[B_CYL_HI], s.cdb[B_CYL_LO], s.cdb[B_HEAD], s.cdb[B_SECT]}; // RL4
      loc_req.cyl = cdb_cyl(s.cdb); // RL5
      loc_req.head = s.cdb[B_HEAD]; // RL5
      loc_req.sect = s.cdb[B_SECT]; // RL5
      status.done = s.done;
      status.good = s.good;
      status.sense = s.sense;
      drive_error_code = s.err;
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      n = s;
      n.rdata = 32'h0000_0000;
      n.done = 1'b0;
      n.fmt_go = 1'b0;
      n.loc_go = 1'b0;
      err_clr = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_CLR_BIT];

      if (reg_wr && (reg_addr == REG_CTRL)) begin
         n.en = reg_wdata[CTRL_EN_BIT];
      end
      // First code is held; a new code wins over a clear in the same cycle
      if ((enc_code != ERR_NONE) && ((s.err == ERR_NONE) || err_clr)) begin
         n.err = enc_code; // RL10
      end else if (err_clr) begin
         n.err = ERR_NONE;
      end

      if (reg_rd) begin
         case (reg_addr)
            REG_CTRL: n.rdata = 32'({1'b0, s.en});
            REG_STATUS: n.rdata = 32'({s.sense, (s.st != ST_CDB), s.st});
            REG_ERR: n.rdata = 32'(s.err);
            REG_ADDR: n.rdata = loc_req.lba;
            REG_LEN: n.rdata = 32'(cdb_len(s.cdb));
            default: n.rdata = 32'h0000_0000;
         endcase
      end

      case (s.st)
         ST_CDB: begin
            if (cdb_valid && s.en) begin
               n.cdb[s.idx] = cdb_byte; // RL20
               if (s.idx == CDB_LAST) begin
                  n.idx = 4'h0;
                  n.st = ST_DECODE;
               end else begin
                  n.idx = s.idx + 4'h1;
               end
            end
         end
         ST_DECODE: begin
            case (s.cdb[B_OP])
               OP_REFORMAT: begin
                  n.fmt_go = 1'b1; // RL1
                  n.st = ST_FMT;
               end
               OP_WRFULL: begin
                  if (cdb_len(s.cdb) != FULL_BLK_LEN) begin
                     n.st = ST_CDB; // RL6
                     n.done = 1'b1;
                     n.good = 1'b0;
                     n.sense = SK_ILLEGAL; // RL6
                  end else begin
                     n.loc_go = 1'b1;
                     n.st = ST_LOCATE;
                  end
               end
               default: begin
                  n.st = ST_CDB;
                  n.done = 1'b1;
                  n.good = 1'b0;
                  n.sense = SK_ILLEGAL;
               end
            endcase
         end
         ST_FMT: begin
            if (fmt_done) begin
               n.st = ST_CDB;
               n.done = 1'b1;
               n.good = fmt_ok;
               n.sense = fmt_ok ? SK_NONE : SK_MEDIUM;
            end
         end
         ST_LOCATE: begin
            // Logical addressing also needs the position check to pass
            if (loc_done) begin
               if (loc_hdr_ok && (loc_req.phys || loc_pos_ok)) begin // RL7 RL4
                  n.st = ST_XFER;
                  n.cnt = 16'h0000;
               end else begin
                  n.st = ST_CDB;
                  n.done = 1'b1;
                  n.good = 1'b0;
                  n.sense = SK_MEDIUM; // RL7
               end
            end
         end
         ST_XFER: begin
            // One byte stage keeps writer data on a flop without a bubble
            if (s.wfull && wr_ready) begin
               n.wfull = 1'b0;
            end
            if (din_valid && din_ready) begin
               n.wbyte = din_byte; // RL3 RL8
               n.wfull = 1'b1;
               n.cnt = s.cnt + 16'h0001;
            end
            if ((s.cnt == FULL_BLK_LEN) && !s.wfull) begin
               n.st = ST_WDONE;
            end
         end
         ST_WDONE: begin
            if (wr_done) begin
               n.st = ST_CDB;
               n.done = 1'b1;
               n.good = wr_ok;
               n.sense = wr_ok ? SK_NONE : SK_MEDIUM;
            end
         end
         default: begin
            n.st = ST_CDB;
         end
      endcase
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         s <= '0;
         s.st <= ST_CDB;
         s.en <= CTRL_EN_RESET;
         s.err <= ERR_NONE;
         s.sense <= SK_NONE;
      end else begin
         s <= n;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   chk_len_reject: assert property ( // RL6
      (s.st == ST_DECODE) && (s.cdb[B_OP] == OP_WRFULL) && (cdb_len(s.cdb) != FULL_BLK_LEN)
      |=> status.done && !status.good && (status.sense == SK_ILLEGAL) && !loc_start)
      else $error("bad transfer length not rejected");

   chk_len_accept: assert property ( // RL6
      (s.st == ST_DECODE) && (s.cdb[B_OP] == OP_WRFULL) && (cdb_len(s.cdb) == FULL_BLK_LEN)
      |=> loc_start && (s.st == ST_LOCATE))
      else $error("good transfer length not started");

   chk_fmt_start: assert property ( // RL1
      (s.st == ST_DECODE) && (s.cdb[B_OP] == OP_REFORMAT)
      |=> fmt_start ##1 !fmt_start && (s.st == ST_FMT || status.done))
      else $error("reformat not started as one pulse");

   chk_fmt_sector: assert property ( // RL2
      fmt_start |-> (fmt_req.sect == 8'h00) && (fmt_req.cyl == {s.cdb[B_CYL_HI], s.cdb[B_CYL_LO]}))
      else $error("reformat address wrong");

   chk_hdr_fail: assert property ( // RL7
      (s.st == ST_LOCATE) && loc_done && !loc_hdr_ok
      |=> status.done && !status.good && (status.sense == SK_MEDIUM) && (s.st == ST_CDB))
      else $error("unreadable prior header not failed");

   chk_logical_pos: assert property ( // RL4
      (s.st == ST_LOCATE) && loc_done && loc_hdr_ok && !loc_req.phys && !loc_pos_ok
      |=> status.done && !status.good && !din_ready)
      else $error("failed position check not failed");

   chk_data_window: assert property ( // RL3
      din_ready |-> (s.st == ST_XFER) && (s.cnt < FULL_BLK_LEN))
      else $error("data taken outside data phase");

   chk_blk_count: assert property ( // RL6
      (s.st == ST_XFER) ##1 (s.st == ST_WDONE) |-> (s.cnt == FULL_BLK_LEN) && !wr_valid)
      else $error("data phase ended at wrong count");

   chk_err_hold: assert property ( // RL10
      (s.err != ERR_NONE) && !err_clr |=> (drive_error_code == $past(drive_error_code)))
      else $error("error code changed without clear");

   chk_err_none: assert property ( // RL19
      (faults == '0) && (s.err == ERR_NONE) |=> (drive_error_code == ERR_NONE))
      else $error("error code set with no fault");

   chk_ctrl_gate: assert property (
      reg_wr && (reg_addr == REG_CTRL) && !reg_wdata[CTRL_EN_BIT] |=> !cdb_ready)
      else $error("disabled decoder still takes descriptors");

   chk_rd_unmapped: assert property (
      reg_rd && (reg_addr > REG_LEN) |=> (reg_rdata == 32'h0000_0000))
      else $error("unmapped read not zero");

   chk_err_set_wins: assert property ( // RL10
      (s.err != ERR_NONE) && err_clr && (enc_code != ERR_NONE) |=> (drive_error_code == $past(enc_code)))
      else $error("new fault lost to a clear in the same cycle");

   chk_err_clear: assert property ( // RL10
      err_clr && (enc_code == ERR_NONE) |=> (drive_error_code == ERR_NONE))
      else $error("error code not cleared");

   chk_cdb_busy: assert property (
      (s.st != ST_CDB) |-> !cdb_ready)
      else $error("descriptor taken while busy");

   chk_done_pulse: assert property (
      status.done |=> !status.done)
      else $error("completion longer than one cycle");

   chk_rd_pulse: assert property (
      !reg_rd |=> (reg_rdata == 32'h0000_0000))
      else $error("read data left standing");

   chk_wr_stall: assert property ( // RL3
      wr_valid && !wr_ready |=> wr_valid && $stable(wr_byte))
      else $error("writer byte dropped or changed while stalled");

   chk_loc_mode: assert property ( // RL4 RL5
      loc_start |-> (loc_req.phys != loc_req.first_phys_only))
      else $error("locate mode flags disagree");

   chk_wr_done: assert property ( // RL3
      (s.st == ST_WDONE) && wr_done |=> status.done && (status.good == $past(wr_ok)))
      else $error("raw write outcome not reported");

   chk_fmt_done: assert property ( // RL1
      (s.st == ST_FMT) && fmt_done |=> status.done && (status.good == $past(fmt_ok)))
      else $error("reformat outcome not reported");

endmodule
`default_nettype wire

// ===== bench/rtw_far_model.sv
// Far side model: reformat engine, block locator and raw block writer
`timescale 1ns/10ps
`default_nettype none
module rtw_far_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Outcomes chosen by the bench
   input wire logic set_ok,
   input wire logic set_hdr,
   input wire logic set_pos,
   // Engine handshakes
   input wire logic fmt_start,
   output logic fmt_done,
   output logic fmt_ok,
   input wire logic loc_start,
   output logic loc_done,
   output logic loc_hdr_ok,
   output logic loc_pos_ok,
   input wire logic wr_valid,
   output logic wr_ready,
   output logic wr_done,
   output logic wr_ok
);
   logic [2:0] fmt_q;
   logic [2:0] loc_q;
   logic [2:0] wr_q;
   logic [9:0] cnt_q;
   logic fin;
   assign fin = wr_valid && wr_ready && cnt_q == 10'h20B;
   // Random reformat and locate answer delays and writer stalls, so slow engines get exercised
   always_ff @(posedge core_clk) begin
      fmt_q <= !rst_b ? 3'h0 : fmt_start ? 3'(1 + $urandom_range(6)) : fmt_q - 3'(fmt_q != 3'h0);
      loc_q <= !rst_b ? 3'h0 : loc_start ? 3'(1 + $urandom_range(6)) : loc_q - 3'(loc_q != 3'h0);
      wr_q <= !rst_b ? 3'h0 : fin ? 3'h3 : wr_q - 3'(wr_q != 3'h0);
      cnt_q <= (!rst_b || fin) ? 10'h000 : cnt_q + 10'(wr_valid && wr_ready);
      wr_ready <= rst_b && $urandom_range(3) != 0;
   end
   // Qualifiers show the opposite value outside their done pulse
   assign fmt_done = fmt_q == 3'h1;
   assign fmt_ok = fmt_done ? set_ok : !set_ok;
   assign loc_done = loc_q == 3'h1;
   assign loc_hdr_ok = loc_done ? set_hdr : !set_hdr;
   assign loc_pos_ok = loc_done ? set_pos : !set_pos;
   assign wr_done = wr_q == 3'h1;
   assign wr_ok = wr_done ? set_ok : !set_ok;
endmodule
`default_nettype wire

// ===== bench/rtw_cmd_decoder_bench.sv
// Self-checking bench for the raw track write command decoder
`timescale 1ns/10ps
`default_nettype none
module rtw_cmd_decoder_bench import rtw_pkg::*; ;
   logic core_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, eadr = 32'h0;
   logic cdb_valid = 1'b0, din_valid = 1'b0, cdb_ready, din_ready;
   logic [7:0] cdb_byte = 8'h00, din_byte = 8'h00, wr_byte, drive_error_code;
   logic fmt_start, fmt_done, fmt_ok, loc_start, loc_done, loc_hdr_ok, loc_pos_ok;
   logic wr_valid, wr_ready, wr_done, wr_ok, rd_p = 1'b0, ephys = 1'b0;
   logic set_ok = 1'b1, set_hdr = 1'b1, set_pos = 1'b1;
   logic [15:0] elen = 16'h0;
   logic [NUM_FAULTS-1:0] faults = '0;
   rtw_fmt_req_t fmt_req;
   rtw_loc_req_t loc_req;
   rtw_status_t status;
   int errors = 0, checks = 0;
   logic [7:0] bq[$];
   logic [4:0] sq[$];
   logic [31:0] rq[$];
   logic [7:0] tbl [NUM_FAULTS] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h0F,
      8'h10, 8'h11, 8'h12, 8'h13, 8'h16, 8'h14, 8'h15, 8'h17, 8'h18, 8'h19,
      8'h1A, 8'h1B, 8'h1C, 8'h1E, 8'h1F, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25};

   rtw_cmd_decoder dut_u (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cdb_valid(cdb_valid), .cdb_byte(cdb_byte),
      .cdb_ready(cdb_ready), .din_valid(din_valid), .din_byte(din_byte), .din_ready(din_ready),
      .fmt_start(fmt_start), .fmt_req(fmt_req), .fmt_done(fmt_done), .fmt_ok(fmt_ok), .loc_start(loc_start),
      .loc_req(loc_req), .loc_done(loc_done), .loc_hdr_ok(loc_hdr_ok), .loc_pos_ok(loc_pos_ok),
      .wr_valid(wr_valid), .wr_byte(wr_byte), .wr_ready(wr_ready), .wr_done(wr_done), .wr_ok(wr_ok),
      .status(status), .faults(faults), .drive_error_code(drive_error_code));
   rtw_far_model far_u (.core_clk(core_clk), .rst_b(rst_b), .set_ok(set_ok), .set_hdr(set_hdr),
      .set_pos(set_pos), .fmt_start(fmt_start), .fmt_done(fmt_done), .fmt_ok(fmt_ok), .loc_start(loc_start),
      .loc_done(loc_done), .loc_hdr_ok(loc_hdr_ok), .loc_pos_ok(loc_pos_ok), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_done(wr_done), .wr_ok(wr_ok));

   always #20 core_clk = ~core_clk;

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Strobe tasks leave an idle cycle so back-to-back calls never reassign a strobe
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
      reg_rd <= 1'b1;
      reg_addr <= a;
      rq.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic put(input logic [7:0] b, input logic dat);
      int k;
      if (dat) begin
         din_valid <= 1'b1;
         din_byte <= b;
         bq.push_back(b);
      end else begin
         cdb_valid <= 1'b1;
         cdb_byte <= b;
      end
      for (k = 0; k < 200; k++) begin
         @(negedge core_clk);
         if (dat ? din_ready : cdb_ready) break;
      end
      @(posedge core_clk);
   endtask

   task automatic cmd(input logic [7:0] op, input logic [7:0] fl, input logic [15:0] len,
                      input logic [4:0] st, input int nd);
      logic [7:0] c [10];
      int i;
      c = '{op, fl, eadr[31:24], eadr[23:16], eadr[15:8], eadr[7:0], 8'h00, len[15:8], len[7:0], 8'h00};
      elen = len;
      ephys = fl[0];
      sq.push_back(st);
      for (i = 0; i < 10; i++) put(c[i], 1'b0);
      cdb_valid <= 1'b0;
      for (i = 0; i < nd; i++) put(8'($urandom), 1'b1);
      din_valid <= 1'b0;
      for (i = 0; i < 3000 && sq.size() + bq.size() != 0; i++) @(posedge core_clk);
      chk(sq.size() + bq.size(), 0);
   endtask

   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ****************************************
   // Output watcher
   // ****************************************
   always @(posedge core_clk) begin
      if (rd_p) chk(reg_rdata, rq.pop_front());
      rd_p = reg_rd;
      if (status.done) chk({status.good, status.sense}, sq.pop_front());
      if (wr_valid && wr_ready) chk(wr_byte, bq.pop_front());
      if (fmt_start) chk({fmt_req.cyl, fmt_req.head, fmt_req.sect, fmt_req.len}, {eadr[31:8], 8'h00, elen});
      if (loc_start && ephys) chk({loc_req.phys, loc_req.cyl, loc_req.head, loc_req.sect}, {1'b1, eadr});
      if (loc_start && !ephys) chk({loc_req.phys, loc_req.first_phys_only, loc_req.lba}, {2'b01, eadr});
   end

   initial begin
      repeat (40000) @(posedge core_clk);
      errors++;
      give_verdict;
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      int i;
      void'($urandom(98));
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      chk(drive_error_code, 8'h00);
      rd_reg(REG_CTRL, 32'h1);
      rd_reg(4'h5, 32'h0);
      wr_reg(REG_CTRL, 32'h0);
      @(negedge core_clk);
      chk(cdb_ready, 1'b0);
      @(posedge core_clk);
      wr_reg(REG_CTRL, 32'h1);
      $display("test registers done");
      eadr = $urandom;
      cmd(OP_REFORMAT, 8'h00, 16'($urandom), 5'h10, 0);
      set_ok <= 1'b0;
      cmd(OP_REFORMAT, 8'h01, 16'($urandom), 5'h03, 0);
      set_ok <= 1'b1;
      $display("test reformat done");
      eadr = $urandom;
      cmd(OP_WRFULL, 8'h01, FULL_BLK_LEN, 5'h10, 524);
      set_hdr <= 1'b0;
      cmd(OP_WRFULL, 8'h01, FULL_BLK_LEN, 5'h03, 0);
      set_hdr <= 1'b1;
      set_pos <= 1'b0;
      cmd(OP_WRFULL, 8'hE0, FULL_BLK_LEN, 5'h03, 0);
      set_pos <= 1'b1;
      cmd(OP_WRFULL, 8'h00, FULL_BLK_LEN, 5'h10, 524);
      set_ok <= 1'b0;
      cmd(OP_WRFULL, 8'h01, FULL_BLK_LEN, 5'h03, 524);
      set_ok <= 1'b1;
      $display("test write full done");
      cmd(OP_WRFULL, 8'h01, 16'h020B, 5'h05, 0);
      cmd(OP_WRFULL, 8'h01, 16'h020D, 5'h05, 0);
      rd_reg(REG_LEN, 32'h020D);
      rd_reg(REG_ADDR, eadr);
      cmd(8'h28, 8'h01, FULL_BLK_LEN, 5'h05, 0);
      rd_reg(REG_STATUS, 32'h50);
      $display("test length done");
      // Bit 29 rides along to prove the lowest fault wins
      for (i = 0; i < NUM_FAULTS; i++) begin
         faults <= (30'h1 << i) | 30'h20000000;
         repeat (3) @(posedge core_clk);
         chk(drive_error_code, tbl[i]);
         faults <= '0;
         rd_reg(REG_ERR, {24'h0, tbl[i]});
         wr_reg(REG_CTRL, 32'h3);
         rd_reg(REG_ERR, 32'h0);
      end
      // Clear and a new fault in one cycle: the new code must stay
      faults <= 30'h2;
      repeat (2) @(posedge core_clk);
      faults <= 30'h1;
      reg_wr <= 1'b1;
      reg_addr <= REG_CTRL;
      reg_wdata <= 32'h3;
      @(posedge core_clk);
      faults <= '0;
      reg_wr <= 1'b0;
      rd_reg(REG_ERR, 32'h3);
      wr_reg(REG_CTRL, 32'h3);
      rd_reg(REG_ERR, 32'h0);
      $display("test error codes done");
      give_verdict;
   end
endmodule
`default_nettype wire
